// *** core/lfd_top.sv ***
// Fault detection, sticky status, channel switch-off and retry for a dual line driver
module lfd_top
  import lfd_pkg::*;
#(
  parameter int unsigned RETRY_PERIOD_CYCLES = lfd_pkg::RETRY_CYCLES,
  parameter int unsigned PULSE_LOW_CYCLES = lfd_pkg::PULSE_CYCLES,
  parameter logic [2:0] DEVICE_TYPE = lfd_pkg::DEVICE_TYPE_DEFAULT
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [lfd_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [lfd_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [lfd_pkg::DATA_W-1:0] REG_RDATA_O,
  input wire logic STANDALONE_I,
  input wire logic DIAGNOSTIC_ENABLE_I,
  input wire logic LEFT_SUPPLY_SHORT_ENABLE_I,
  input wire logic LEFT_GROUND_SHORT_ENABLE_I,
  input wire logic TEMPERATURE_WARNING_ENABLE_I,
  input wire logic THERMAL_SHUTDOWN_ENABLE_I,
  input wire logic LEFT_SUPPLY_SHORT_I,
  input wire logic LEFT_GROUND_SHORT_I,
  input wire logic RIGHT_SUPPLY_SHORT_I,
  input wire logic RIGHT_GROUND_SHORT_I,
  input wire logic TEMP_WARNING_I,
  input wire logic THERMAL_SHUTDOWN_I,
  output logic FAULT_N_O,
  output logic LEFT_HIGHZ_O,
  output logic RIGHT_HIGHZ_O
);
  import lfd_pkg::*;

  generate
    if (RETRY_PERIOD_CYCLES < 2 || PULSE_LOW_CYCLES < 1 ||
        PULSE_LOW_CYCLES >= RETRY_PERIOD_CYCLES) begin : g_chk
      $error("lfd_top: retry period must exceed pulse width");
    end
  endgenerate

  logic [5:0] cond;
  logic ls_c, lg_c, rs_c, rg_c, tw_c, ts_c;
  logic [7:0] rden_r, rden_nxt;
  logic [7:0] left_fault_register_r, left_fault_register_nxt, right_fault_register_r, right_fault_register_nxt, general_fault_register_r, general_fault_register_nxt;
  logic loff_r, loff_nxt, roff_r, roff_nxt;
  logic [TIMER_W-1:0] tmr_r, tmr_nxt;
  logic fault_n_r, fault_n_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic wr_cmd, wr_rden, rd_l, rd_r, rd_g, retry_tick, summary;
  logic en_ls, en_lg, en_rs, en_rg, en_tw, en_ts;

  lfd_sync #(.WIDTH(6)) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .async_i({LEFT_SUPPLY_SHORT_I, LEFT_GROUND_SHORT_I, RIGHT_SUPPLY_SHORT_I,
              RIGHT_GROUND_SHORT_I, TEMP_WARNING_I, THERMAL_SHUTDOWN_I}),
    .level_o(cond)
  );
  assign {ls_c, lg_c, rs_c, rg_c, tw_c, ts_c} = cond;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  assign wr_cmd = REG_WR_I && hit(REG_ADDR_I, ADDR_COMMAND);
  assign wr_rden = REG_WR_I && hit(REG_ADDR_I, ADDR_RIGHT_DETECT_ENABLE);
  assign rd_g = REG_RD_I && hit(REG_ADDR_I, ADDR_GENERAL_FAULT);
  assign rd_l = REG_RD_I && hit(REG_ADDR_I, ADDR_LEFT_FAULT);
  assign rd_r = REG_RD_I && hit(REG_ADDR_I, ADDR_RIGHT_FAULT);
  assign retry_tick = STANDALONE_I && (tmr_r == '0);

  always_comb begin
    en_ls = DIAGNOSTIC_ENABLE_I && LEFT_SUPPLY_SHORT_ENABLE_I;
    en_lg = DIAGNOSTIC_ENABLE_I && LEFT_GROUND_SHORT_ENABLE_I;
    en_rs = DIAGNOSTIC_ENABLE_I && rden_r[BIT_SUPPLY_SHORT];
    en_rg = DIAGNOSTIC_ENABLE_I && rden_r[BIT_GROUND_SHORT];
    en_tw = DIAGNOSTIC_ENABLE_I && TEMPERATURE_WARNING_ENABLE_I;
    en_ts = DIAGNOSTIC_ENABLE_I && THERMAL_SHUTDOWN_ENABLE_I;
  end

  // Right detect-enable register, bits 4, 1 and 0 stay zero
  always_comb begin
    rden_nxt = rden_r;
    if (wr_rden) begin
      rden_nxt = REG_WDATA_I & RIGHT_DETECT_ENABLE_WMASK;
    end
  end

  // Sticky bits cleared by read, set wins over clear
  // Present condition sets the bit again
  always_comb begin
    left_fault_register_nxt = rd_l ? FAULT_REG_RESET : left_fault_register_r;
    right_fault_register_nxt = rd_r ? FAULT_REG_RESET : right_fault_register_r;
    general_fault_register_nxt = general_fault_register_r;
    if (en_ls && ls_c) left_fault_register_nxt[BIT_SUPPLY_SHORT] = 1'b1;
    if (en_rs && rs_c) right_fault_register_nxt[BIT_SUPPLY_SHORT] = 1'b1;
    if (en_lg && lg_c) left_fault_register_nxt[BIT_GROUND_SHORT] = 1'b1;
    if (en_rg && rg_c) right_fault_register_nxt[BIT_GROUND_SHORT] = 1'b1;
    // Warning clears on read once below threshold
    if (rd_g && !tw_c) general_fault_register_nxt[BIT_TEMP_WARN] = 1'b0;
    if (en_tw && tw_c) general_fault_register_nxt[BIT_TEMP_WARN] = 1'b1;
    if (rd_g && !ts_c) general_fault_register_nxt[BIT_THERMAL_SHDN] = 1'b0;
    if (en_ts && ts_c) general_fault_register_nxt[BIT_THERMAL_SHDN] = 1'b1;
  end

  // Held off until retry bit written or, in standalone mode, the retry timer reaches zero
  always_comb begin
    loff_nxt = loff_r;
    roff_nxt = roff_r;
    if ((wr_cmd && REG_WDATA_I[BIT_LEFT_RESTART]) || retry_tick) loff_nxt = 1'b0;
    if ((wr_cmd && REG_WDATA_I[BIT_RIGHT_RESTART]) || retry_tick) roff_nxt = 1'b0;
    if (ls_c || lg_c || ts_c) loff_nxt = 1'b1;
    if (rs_c || rg_c || ts_c) roff_nxt = 1'b1;
  end

  always_comb begin
    if (!STANDALONE_I || tmr_r == '0) begin
      tmr_nxt = TIMER_W'(RETRY_PERIOD_CYCLES - 1);
    end else begin
      tmr_nxt = tmr_r - 1'b1;
    end
  end

  // Pin low on any status bit when not standalone; in standalone mode it pulses low while a channel is off
  always_comb begin
    summary = (|left_fault_register_nxt) || (|right_fault_register_nxt) || (|general_fault_register_nxt);
    if (STANDALONE_I) begin
      fault_n_nxt = !((loff_nxt || roff_nxt) &&
                      (tmr_nxt >= TIMER_W'(RETRY_PERIOD_CYCLES - PULSE_LOW_CYCLES)));
    end else begin
      fault_n_nxt = !summary;
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        ADDR_GENERAL_FAULT: rdata_nxt = general_fault_register_r;
        ADDR_LEFT_FAULT: rdata_nxt = left_fault_register_r;
        ADDR_RIGHT_FAULT: rdata_nxt = right_fault_register_r;
        ADDR_FLAG: begin
          rdata_nxt = {!fault_n_r, loff_r, roff_r, 2'b00, DEVICE_TYPE};
        end
        ADDR_RIGHT_DETECT_ENABLE: rdata_nxt = rden_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rden_r <= RIGHT_DETECT_ENABLE_RESET;
      left_fault_register_r <= FAULT_REG_RESET;
      right_fault_register_r <= FAULT_REG_RESET;
      general_fault_register_r <= FAULT_REG_RESET;
      loff_r <= 1'b0;
      roff_r <= 1'b0;
      tmr_r <= '0;
      fault_n_r <= 1'b1;
      rdata_r <= 8'h00;
    end else begin
      rden_r <= rden_nxt;
      left_fault_register_r <= left_fault_register_nxt;
      right_fault_register_r <= right_fault_register_nxt;
      general_fault_register_r <= general_fault_register_nxt;
      loff_r <= loff_nxt;
      roff_r <= roff_nxt;
      tmr_r <= tmr_nxt;
      fault_n_r <= fault_n_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA_O = rdata_r;
  assign FAULT_N_O = fault_n_r;
  assign LEFT_HIGHZ_O = loff_r;
  assign RIGHT_HIGHZ_O = roff_r;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  a_rden_reserved: assert property (rden_r[4] == 1'b0 && rden_r[1:0] == 2'b00)
    else $error("reserved enable bits set");
  a_disabled_quiet: assert property (!rden_r[BIT_SUPPLY_SHORT] && !rd_r
    |=> right_fault_register_r[BIT_SUPPLY_SHORT] == $past(right_fault_register_r[BIT_SUPPLY_SHORT]))
    else $error("disabled supply short flagged");
  a_supply_off: assert property (rs_c |=> RIGHT_HIGHZ_O)
    else $error("right channel not off on supply short");
  a_supply_flag: assert property (en_rs && rs_c |=> right_fault_register_r[BIT_SUPPLY_SHORT])
    else $error("supply short status not set");
  a_ground_flag: assert property (en_lg && lg_c |=> left_fault_register_r[BIT_GROUND_SHORT])
    else $error("ground short status not set");
  a_read_clear: assert property (rd_l && !(en_ls && ls_c) && !(en_lg && lg_c)
    |=> left_fault_register_r == 8'h00)
    else $error("read did not clear left status");
  a_shdn_both: assert property (ts_c |=> LEFT_HIGHZ_O && RIGHT_HIGHZ_O)
    else $error("shutdown did not turn both channels off");
  a_off_held: assert property (LEFT_HIGHZ_O && !wr_cmd && !retry_tick
    |=> LEFT_HIGHZ_O)
    else $error("left channel resumed without retry");
  a_pin_summary: assert property (!STANDALONE_I && !$past(STANDALONE_I) && (|right_fault_register_r)
    |-> !FAULT_N_O)
    else $error("pin not low with right status set");
  a_retry_clear: assert property (wr_cmd && REG_WDATA_I[BIT_RIGHT_RESTART] && !rs_c
    && !rg_c && !ts_c |=> !RIGHT_HIGHZ_O)
    else $error("right retry did not resume channel");
endmodule

// *** include/lfd_pkg.sv ***
// Register map, field positions and timing constants for the line-driver fault logic
package lfd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ADDR_COMMAND = 8'h01;
  localparam logic [7:0] ADDR_GENERAL_FAULT = 8'h02;
  localparam logic [7:0] ADDR_LEFT_FAULT = 8'h03;
  localparam logic [7:0] ADDR_RIGHT_FAULT = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h05;
  localparam logic [7:0] ADDR_RIGHT_DETECT_ENABLE = 8'h08;
  localparam logic [7:0] RIGHT_DETECT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] RIGHT_DETECT_ENABLE_WMASK = 8'hEC;
  localparam logic [7:0] FAULT_REG_RESET = 8'h00;
  // Channel fault and enable field positions
  localparam int unsigned BIT_SUPPLY_SHORT = 7;
  localparam int unsigned BIT_GROUND_SHORT = 6;
  localparam int unsigned BIT_OVERCURRENT = 5;
  localparam int unsigned BIT_OFFSET = 3;
  localparam int unsigned BIT_OPEN_LOAD = 2;
  // General fault field positions
  localparam int unsigned BIT_TEMP_WARN = 6;
  localparam int unsigned BIT_THERMAL_SHDN = 5;
  localparam int unsigned BIT_OVERVOLTAGE = 4;
  // Command register retry positions
  localparam int unsigned BIT_LEFT_RESTART = 7;
  localparam int unsigned BIT_RIGHT_RESTART = 6;
  // Flag register positions
  localparam int unsigned BIT_FLAG_SUMMARY = 7;
  localparam int unsigned BIT_LEFT_HIGHZ = 6;
  localparam int unsigned BIT_RIGHT_HIGHZ = 5;
  // Device type field, value arbitrary
  localparam logic [2:0] DEVICE_TYPE_DEFAULT = 3'h5;
  // Timing
  localparam int unsigned CLK_FREQ_KHZ = 200000;
  localparam int unsigned RETRY_PERIOD_MS = 500;
  localparam int unsigned RETRY_CYCLES = RETRY_PERIOD_MS * CLK_FREQ_KHZ;
  localparam int unsigned PULSE_WIDTH_US = 1000;
  localparam int unsigned PULSE_CYCLES = PULSE_WIDTH_US * CLK_FREQ_KHZ / 1000;
  localparam int unsigned TIMER_W = 32;
endpackage

// *** core/lfd_sync.sv ***
// Three-stage input synchroniser that accepts a change once stages two and three agree
module lfd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [WIDTH-1:0] lvl_nxt;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("lfd_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_o = lvl_r;
endmodule

// *** test/lfd_host_model.sv ***
// Register host model that drives the strobe port of the fault block
module lfd_host_model
  import lfd_pkg::*;
(
  input wire logic clk_i,
  input wire logic [lfd_pkg::DATA_W-1:0] rdata_i,
  output logic [lfd_pkg::ADDR_W-1:0] addr_o,
  output logic [lfd_pkg::DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    q = rdata_i;
  endtask
endmodule

// *** test/test_lfd_top.sv ***
// Self-checking bench for the line-driver fault logic
module test_lfd_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lfd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stand = 1'b0;
  logic diagnostic_enable = 1'b0;
  logic [3:0] en = 4'h0;
  logic [5:0] flt = 6'h00;
  logic [7:0] addr, wdata, rdata, q;
  logic wr, rd, fault_n, lhz, rhz;
  int failures = 0;
  int check_count = 0;
  int seed = 15478;
  int cyc = 0;
  int m_mask, lo, hi;
  int exp_q[$];
  initial begin
    forever #2.5 clk = ~clk;
  end
  lfd_host_model host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  lfd_top #(.RETRY_PERIOD_CYCLES(64), .PULSE_LOW_CYCLES(8)) uut (.CLK_SYS_I(clk),
    .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .STANDALONE_I(stand), .DIAGNOSTIC_ENABLE_I(diagnostic_enable),
    .LEFT_SUPPLY_SHORT_ENABLE_I(en[3]), .LEFT_GROUND_SHORT_ENABLE_I(en[2]),
    .TEMPERATURE_WARNING_ENABLE_I(en[1]), .THERMAL_SHUTDOWN_ENABLE_I(en[0]),
    .LEFT_SUPPLY_SHORT_I(flt[5]), .LEFT_GROUND_SHORT_I(flt[4]),
    .RIGHT_SUPPLY_SHORT_I(flt[3]), .RIGHT_GROUND_SHORT_I(flt[2]),
    .TEMP_WARNING_I(flt[1]), .THERMAL_SHUTDOWN_I(flt[0]), .FAULT_N_O(fault_n),
    .LEFT_HIGHZ_O(lhz), .RIGHT_HIGHZ_O(rhz));
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q);
    chk(q, e);
  endtask
  task automatic inj(input int b, input logic v);
    @(posedge clk);
    flt[b] <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_RIGHT_DETECT_ENABLE, 8'h00);
    rchk(8'h7F, 8'h00);
    chk({7'h00, fault_n}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      m_mask = $random(seed);
      exp_q.push_back(m_mask & 32'h000000EC);
      host.wr(ADDR_RIGHT_DETECT_ENABLE, m_mask[7:0]);
      rchk(ADDR_RIGHT_DETECT_ENABLE, 8'(exp_q.pop_front()));
    end
    host.wr(ADDR_RIGHT_DETECT_ENABLE, 8'hC0);
    diagnostic_enable <= 1'b1;
    en <= 4'hF;
    inj(3, 1'b1);
    chk({6'h00, rhz, fault_n}, 8'h02);
    host.rd(ADDR_FLAG, q);
    chk(q & 8'hE0, 8'hA0);
    chk(q & 8'h1F, {5'h00, DEVICE_TYPE_DEFAULT});
    rchk(ADDR_RIGHT_FAULT, 8'h80);
    inj(3, 1'b0);
    rchk(ADDR_RIGHT_FAULT, 8'h80);
    rchk(ADDR_RIGHT_FAULT, 8'h00);
    chk({7'h00, rhz}, 8'h01);
    host.wr(ADDR_COMMAND, 8'h40);
    #1;
    chk({6'h00, rhz, fault_n}, 8'h01);
    host.wr(ADDR_RIGHT_DETECT_ENABLE, 8'h00);
    inj(2, 1'b1);
    chk({7'h00, rhz}, 8'h01);
    rchk(ADDR_RIGHT_FAULT, 8'h00);
    host.wr(ADDR_RIGHT_DETECT_ENABLE, 8'h40);
    inj(2, 1'b1);
    rchk(ADDR_RIGHT_FAULT, 8'h40);
    inj(2, 1'b0);
    rchk(ADDR_RIGHT_FAULT, 8'h40);
    host.wr(ADDR_COMMAND, 8'h40);
    inj(5, 1'b1);
    chk({7'h00, lhz}, 8'h01);
    rchk(ADDR_LEFT_FAULT, 8'h80);
    inj(5, 1'b0);
    host.wr(ADDR_COMMAND, 8'h80);
    #1;
    chk({7'h00, lhz}, 8'h00);
    inj(4, 1'b1);
    chk({7'h00, lhz}, 8'h01);
    rchk(ADDR_LEFT_FAULT, 8'hC0);
    inj(4, 1'b0);
    rchk(ADDR_LEFT_FAULT, 8'h40);
    rchk(ADDR_LEFT_FAULT, 8'h00);
    host.wr(ADDR_COMMAND, 8'h80);
    diagnostic_enable <= 1'b0;
    host.wr(ADDR_RIGHT_DETECT_ENABLE, 8'hC0);
    inj(3, 1'b1);
    rchk(ADDR_RIGHT_FAULT, 8'h00);
    inj(3, 1'b0);
    host.wr(ADDR_COMMAND, 8'h40);
    diagnostic_enable <= 1'b1;
    inj(0, 1'b1);
    chk({6'h00, lhz, rhz}, 8'h03);
    rchk(ADDR_GENERAL_FAULT, 8'h20);
    inj(0, 1'b0);
    host.wr(ADDR_COMMAND, 8'h40);
    #1;
    chk({6'h00, lhz, rhz}, 8'h02);
    host.wr(ADDR_COMMAND, 8'h80);
    rchk(ADDR_GENERAL_FAULT, 8'h20);
    inj(1, 1'b1);
    rchk(ADDR_GENERAL_FAULT, 8'h40);
    chk({7'h00, fault_n}, 8'h00);
    inj(1, 1'b0);
    rchk(ADDR_GENERAL_FAULT, 8'h40);
    rchk(ADDR_GENERAL_FAULT, 8'h00);
    @(posedge clk);
    stand <= 1'b1;
    inj(3, 1'b1);
    lo = 0;
    hi = 0;
    repeat (128) begin
      @(posedge clk);
      #1;
      if (fault_n === 1'b0) lo++;
      else hi++;
    end
    chk({6'h00, lo != 0, hi != 0}, 8'h03);
    inj(3, 1'b0);
    repeat (140) @(posedge clk);
    #1;
    chk({7'h00, rhz}, 8'h00);
    report_and_stop;
  end
endmodule
